// File: hdl/rsld_pkg.sv
// Shared constants and types for the reset strap latch and decoder.
package rsld_pkg;

    // Number of downstream ports covered by the disable straps.
    localparam int RSLD_NUM_PORTS = 6;

    // Reference clock period and the strap settle time after reset release.
    localparam int RSLD_CLK_PERIOD_NS = 20;
    localparam int RSLD_SETTLE_NS = 100;
    // Least time, so the cycle count rounds up.
    localparam int RSLD_SETTLE_CYC_INT = (RSLD_SETTLE_NS + RSLD_CLK_PERIOD_NS - 1)
        / RSLD_CLK_PERIOD_NS;
    localparam logic [2:0] RSLD_SETTLE_CYCLES = 3'(RSLD_SETTLE_CYC_INT);
    localparam logic [2:0] RSLD_CNT_RESET = 3'h0;

    // Sensed resistor strength of the mode strap.
    localparam logic [1:0] RSLD_STRENGTH_WEAK = 2'h0;
    localparam logic [1:0] RSLD_STRENGTH_MEDIUM = 2'h1;
    localparam logic [1:0] RSLD_STRENGTH_STRONG = 2'h2;

    // Decoded mode codes, one per resistor setting, plus RSLD_MODE_NONE for no setting.
    localparam logic [2:0] RSLD_BRIDGE_MASTER_SETTING = 3'h0;
    localparam logic [2:0] RSLD_CONFIG_SLAVE_SETTING = 3'h1;
    localparam logic [2:0] RSLD_RESERVED_SETTING_A = 3'h2;
    localparam logic [2:0] RSLD_RESERVED_SETTING_B = 3'h3;
    localparam logic [2:0] RSLD_RESERVED_SETTING_C = 3'h4;
    localparam logic [2:0] RSLD_RESERVED_SETTING_D = 3'h5;
    localparam logic [2:0] RSLD_MODE_NONE = 3'h7;

    // Reset values of the captured outputs and the sequencing status flags.
    localparam logic RSLD_FLAG_RESET = 1'h0;
    localparam logic RSLD_STANDBY_RESET = 1'h1;

    // Sensed mode strap: pull direction and resistor strength.
    typedef struct packed {
        logic pull_up;
        logic [1:0] strength;
    } rsld_mode_sense_t;

    // Per-port D+ and D- disable straps, ports 6 down to 1.
    typedef struct packed {
        logic [6:1] port_dplus_disable_strap;
        logic [6:1] port_dminus_disable_strap;
    } rsld_port_straps_t;

    // Strap sequencing states, Gray coded along the path.
    typedef enum logic [1:0] {
        RSLD_ST_SETTLE = 2'h0,
        RSLD_ST_CAPTURE = 2'h1,
        RSLD_ST_RUN = 2'h3
    } rsld_state_t;

endpackage : rsld_pkg

// File: hdl/rsld_port_cell.sv
// Capture and disable decode for the straps of one downstream port.
`timescale 1ns/1ns
module rsld_port_cell
    import rsld_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Capture strobe and the raw strap levels.
    input wire logic capture,
    input wire logic dplus_strap,
    input wire logic dminus_strap,
    // Captured values and decoded disables.
    output logic dplus_reg,
    output logic dminus_reg,
    output logic hs_disable_reg,
    output logic ss_disable_reg
);

    logic dplus_next;
    logic dminus_next;
    logic hs_disable_next;
    logic ss_disable_next;

    // The straps are only looked at on the capture strobe; otherwise they hold.
    always_comb
    begin
        dplus_next = dplus_reg;
        dminus_next = dminus_reg;
        hs_disable_next = hs_disable_reg;
        ss_disable_next = ss_disable_reg;
        if (capture)
        begin
            dplus_next = dplus_strap;
            dminus_next = dminus_strap;
            // One high strap alone leaves the port running.
            hs_disable_next = dplus_strap & dminus_strap;
            ss_disable_next = dplus_strap & dminus_strap;
        end
    end

    // Registers return to enabled while reset is held.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dplus_reg <= RSLD_FLAG_RESET;
            dminus_reg <= RSLD_FLAG_RESET;
            hs_disable_reg <= RSLD_FLAG_RESET;
            ss_disable_reg <= RSLD_FLAG_RESET;
        end
        else
        begin
            dplus_reg <= dplus_next;
            dminus_reg <= dminus_next;
            hs_disable_reg <= hs_disable_next;
            ss_disable_reg <= ss_disable_next;
        end
    end

endmodule : rsld_port_cell

// File: hdl/rsld_top.sv
// Reset strap latch: captures configuration straps at reset release and decodes them.
`timescale 1ns/1ns
module rsld_top
    import rsld_pkg::*;
(
    // Clock and resets.
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic POR_N,
    // Strap levels seen on the shared pins.
    input wire rsld_mode_sense_t MODE_SENSE,
    input wire rsld_port_straps_t PORT_STRAPS,
    // Decoded mode.
    output logic [2:0] MODE_CODE,
    output logic BRIDGE_MASTER,
    output logic CONFIG_SLAVE,
    output logic MODE_RESERVED,
    // Sequencing status.
    output logic STANDBY,
    output logic STRAP_PINS_RELEASED,
    // Captured port straps and decoded port disables.
    output rsld_port_straps_t PORT_STRAPS_CAPTURED,
    output logic [6:1] HS_PORT_DISABLE,
    output logic [6:1] SS_PORT_DISABLE
);

    // Either reset source holds the whole block at defaults. There is no
    // synchroniser on the release, so both resets must lift clear of a clock
    // edge or the registers could leave reset on different edges.
    logic rst_n;
    assign rst_n = NRST & POR_N;

    // Sequencer state and settle counter.
    rsld_state_t state_reg;
    rsld_state_t state_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;

    // Captured mode decode.
    logic [2:0] mode_code_reg;
    logic [2:0] mode_code_next;
    logic bridge_reg;
    logic bridge_next;
    logic slave_reg;
    logic slave_next;
    logic reserved_reg;
    logic reserved_next;

    // Sequencing status flags.
    logic standby_reg;
    logic standby_next;
    logic released_reg;
    logic released_next;

    // Capture strobe and the mode code the pins show right now.
    logic capture;
    logic [2:0] sensed_code;

    // Capture happens on exactly one edge after each reset release. Every
    // register that keeps a strap value loads on this strobe and no other.
    assign capture = (state_reg == RSLD_ST_CAPTURE);

    // Map pull direction and strength to the six-setting code.
    always_comb
    begin
        case (MODE_SENSE.strength)
            // Weak resistors pick the two working roles of the two-wire port.
            RSLD_STRENGTH_WEAK:
                sensed_code = MODE_SENSE.pull_up ? RSLD_CONFIG_SLAVE_SETTING
                                                 : RSLD_BRIDGE_MASTER_SETTING;
            // Medium and strong resistors only reach reserved settings.
            RSLD_STRENGTH_MEDIUM:
                sensed_code = MODE_SENSE.pull_up ? RSLD_RESERVED_SETTING_B
                                                 : RSLD_RESERVED_SETTING_A;
            RSLD_STRENGTH_STRONG:
                sensed_code = MODE_SENSE.pull_up ? RSLD_RESERVED_SETTING_D
                                                 : RSLD_RESERVED_SETTING_C;
            // An invalid strength has no setting and is flagged as reserved.
            default:
                sensed_code = RSLD_MODE_NONE;
        endcase
    end

    // Sequencer: wait for straps to settle, capture once, then run.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        standby_next = RSLD_FLAG_RESET;
        released_next = released_reg;
        case (state_reg)
            RSLD_ST_SETTLE:
            begin
                // The wait gives slow strap resistors time after reset lifts.
                if (cnt_reg >= RSLD_SETTLE_CYCLES - 3'h1)
                begin
                    state_next = RSLD_ST_CAPTURE;
                end
                else
                begin
                    cnt_next = cnt_reg + 3'h1;
                end
            end
            RSLD_ST_CAPTURE:
            begin
                // Straps are latched on this edge; the pins go back to normal use.
                state_next = RSLD_ST_RUN;
                released_next = 1'h1;
            end
            RSLD_ST_RUN:
            begin
                // Nothing is sampled again until the next reset release.
                state_next = RSLD_ST_RUN;
            end
            default:
            begin
                // An unused state code restarts the settle wait.
                state_next = RSLD_ST_SETTLE;
                cnt_next = RSLD_CNT_RESET;
            end
        endcase
    end

    // Mode decode is loaded only on the capture edge and then frozen.
    always_comb
    begin
        mode_code_next = mode_code_reg;
        bridge_next = bridge_reg;
        slave_next = slave_reg;
        reserved_next = reserved_reg;
        // Outside the capture edge the decode holds, so later pin traffic cannot leak in.
        if (capture)
        begin
            mode_code_next = sensed_code;
            bridge_next = (sensed_code == RSLD_BRIDGE_MASTER_SETTING);
            slave_next = (sensed_code == RSLD_CONFIG_SLAVE_SETTING);
            // Reserved settings select neither role of the two-wire port.
            reserved_next = (sensed_code != RSLD_BRIDGE_MASTER_SETTING)
                && (sensed_code != RSLD_CONFIG_SLAVE_SETTING);
        end
    end

    // Sequencer registers fall back to standby defaults while either reset is low.
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= RSLD_ST_SETTLE;
            cnt_reg <= RSLD_CNT_RESET;
            standby_reg <= RSLD_STANDBY_RESET;
            released_reg <= RSLD_FLAG_RESET;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            standby_reg <= standby_next;
            released_reg <= released_next;
        end
    end

    // Mode registers forget the last capture while either reset is low.
    always_ff @(posedge REF_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_code_reg <= RSLD_MODE_NONE;
            bridge_reg <= RSLD_FLAG_RESET;
            slave_reg <= RSLD_FLAG_RESET;
            reserved_reg <= RSLD_FLAG_RESET;
        end
        else
        begin
            mode_code_reg <= mode_code_next;
            bridge_reg <= bridge_next;
            slave_reg <= slave_next;
            reserved_reg <= reserved_next;
        end
    end

    // One cell per downstream port, ports numbered 6 down to 1.
    // All cells share one capture strobe, so every port latches on the same edge.
    generate
        for (genvar p = 1; p <= RSLD_NUM_PORTS; p++)
        begin : g_port
            rsld_port_cell u_cell (
                .clk(REF_CLK),
                .rst_n(rst_n),
                .capture(capture),
                .dplus_strap(PORT_STRAPS.port_dplus_disable_strap[p]),
                .dminus_strap(PORT_STRAPS.port_dminus_disable_strap[p]),
                .dplus_reg(PORT_STRAPS_CAPTURED.port_dplus_disable_strap[p]),
                .dminus_reg(PORT_STRAPS_CAPTURED.port_dminus_disable_strap[p]),
                .hs_disable_reg(HS_PORT_DISABLE[p]),
                .ss_disable_reg(SS_PORT_DISABLE[p])
            );
        end
    endgenerate

    // Outputs come straight from registers.
    assign MODE_CODE = mode_code_reg;
    assign BRIDGE_MASTER = bridge_reg;
    assign CONFIG_SLAVE = slave_reg;
    assign MODE_RESERVED = reserved_reg;

    // Status flags are registers of the sequencer.
    assign STANDBY = standby_reg;
    assign STRAP_PINS_RELEASED = released_reg;

endmodule : rsld_top

// File: sim/rsld_top_sva.sv
// Assertion checker for the reset strap latch, bound to its top module.
`timescale 1ns/1ns
module rsld_top_sva
    import rsld_pkg::*;
(
    // Clock and resets.
    input wire logic REF_CLK,
    input wire logic NRST,
    input wire logic POR_N,
    // Strap levels on the pins.
    input wire rsld_mode_sense_t MODE_SENSE,
    input wire rsld_port_straps_t PORT_STRAPS,
    // Decoded and captured outputs.
    input wire logic [2:0] MODE_CODE,
    input wire logic BRIDGE_MASTER,
    input wire logic CONFIG_SLAVE,
    input wire logic MODE_RESERVED,
    input wire logic STANDBY,
    input wire logic STRAP_PINS_RELEASED,
    input wire rsld_port_straps_t PORT_STRAPS_CAPTURED,
    input wire logic [6:1] HS_PORT_DISABLE,
    input wire logic [6:1] SS_PORT_DISABLE
);
    // Either reset source holds the block, so both must be high.
    wire logic rst_ok = NRST & POR_N;
    // Expected code; an invalid strength has no setting of its own.
    wire logic [2:0] exp_code = (MODE_SENSE.strength == 2'h3) ? RSLD_MODE_NONE
        : {MODE_SENSE.strength, MODE_SENSE.pull_up};
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!rst_ok);
    // Settle wait, then one capture of what the pins showed at the capture edge.
    sequence s_waiting;
        !STRAP_PINS_RELEASED [*6];
    endsequence
    sequence s_captured;
        STRAP_PINS_RELEASED && PORT_STRAPS_CAPTURED == $past(PORT_STRAPS)
            && MODE_CODE == $past(exp_code);
    endsequence
    a_capture_edge: assert property ($rose(rst_ok) |-> s_waiting ##1 s_captured)
        else $error("straps not captured on the sixth edge");
    a_standby_exit: assert property ($rose(rst_ok) |-> STANDBY ##1 !STANDBY)
        else $error("standby not left one edge after release");
    a_reset_defaults: assert property (disable iff (1'b0) !rst_ok |-> STANDBY
        && MODE_CODE == RSLD_MODE_NONE && !STRAP_PINS_RELEASED && PORT_STRAPS_CAPTURED == '0)
        else $error("outputs not at defaults in reset");
    a_flags_decode: assert property (STRAP_PINS_RELEASED |->
        BRIDGE_MASTER == (MODE_CODE == RSLD_BRIDGE_MASTER_SETTING)
        && CONFIG_SLAVE == (MODE_CODE == RSLD_CONFIG_SLAVE_SETTING))
        else $error("mode flag disagrees with mode code");
    a_reserved_flag: assert property (STRAP_PINS_RELEASED |->
        MODE_RESERVED == (MODE_CODE > RSLD_CONFIG_SLAVE_SETTING))
        else $error("reserved flag disagrees with mode code");
    a_port_pairing: assert property (HS_PORT_DISABLE ==
        (PORT_STRAPS_CAPTURED.port_dplus_disable_strap & PORT_STRAPS_CAPTURED.port_dminus_disable_strap))
        else $error("port disable is not the pair of straps");
    a_ss_follows: assert property (SS_PORT_DISABLE == HS_PORT_DISABLE)
        else $error("superspeed disable differs from high speed");
    a_capture_hold: assert property (STRAP_PINS_RELEASED |=> STRAP_PINS_RELEASED
        && $stable(MODE_CODE) && $stable(PORT_STRAPS_CAPTURED))
        else $error("captured value moved after capture");
endmodule : rsld_top_sva

bind rsld_top rsld_top_sva u_sva (.REF_CLK, .NRST, .POR_N, .MODE_SENSE, .PORT_STRAPS,
    .MODE_CODE, .BRIDGE_MASTER, .CONFIG_SLAVE, .MODE_RESERVED, .STANDBY,
    .STRAP_PINS_RELEASED, .PORT_STRAPS_CAPTURED, .HS_PORT_DISABLE, .SS_PORT_DISABLE);

// File: sim/rsld_strap_board.sv
// Board model: strap resistors before sampling, pin traffic afterwards.
`timescale 1ns/1ns
module rsld_strap_board
    import rsld_pkg::*;
(
    // Clock and the pin release status.
    input wire logic clk,
    input wire logic released,
    // Fitted mode setting {strength, pull_up} and port straps.
    input wire logic [2:0] setting,
    input wire logic [11:0] straps,
    // Levels seen on the pins.
    output rsld_mode_sense_t mode_sense,
    output rsld_port_straps_t port_straps
);
    logic toggle_reg = 1'b0;
    // Normal pin traffic changes every cycle, so a late sample shows up.
    always @(posedge clk)
    begin
        toggle_reg <= ~toggle_reg;
    end
    // Straps stand steady until the device has sampled them.
    assign mode_sense = released ? {3{toggle_reg}} : {setting[0], setting[2:1]};
    assign port_straps = released ? {12{toggle_reg}} : straps;
endmodule : rsld_strap_board

// File: sim/tb.sv
// Self-checking bench for the reset strap latch.
`timescale 1ns/1ns
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h expected %0h", $time, got, exp); end end
module tb;
    import rsld_pkg::*;
    logic REF_CLK = 1'b0;
    logic NRST = 1'b1;
    logic POR_N = 1'b1;
    logic [2:0] setting = 3'h0;
    logic [11:0] straps = 12'h000;
    rsld_mode_sense_t MODE_SENSE;
    rsld_port_straps_t PORT_STRAPS;
    rsld_port_straps_t PORT_STRAPS_CAPTURED;
    logic [2:0] MODE_CODE;
    logic BRIDGE_MASTER, CONFIG_SLAVE, MODE_RESERVED, STANDBY, STRAP_PINS_RELEASED;
    logic [6:1] HS_PORT_DISABLE, SS_PORT_DISABLE;
    int n_mismatch = 0;
    int n_checks = 0;
    // Reference clock at 50 MHz.
    always #10 REF_CLK = ~REF_CLK;
    rsld_top dut (.REF_CLK(REF_CLK), .NRST(NRST), .POR_N(POR_N), .MODE_SENSE(MODE_SENSE),
        .PORT_STRAPS(PORT_STRAPS), .MODE_CODE(MODE_CODE), .BRIDGE_MASTER(BRIDGE_MASTER),
        .CONFIG_SLAVE(CONFIG_SLAVE), .MODE_RESERVED(MODE_RESERVED), .STANDBY(STANDBY),
        .STRAP_PINS_RELEASED(STRAP_PINS_RELEASED), .PORT_STRAPS_CAPTURED(PORT_STRAPS_CAPTURED),
        .HS_PORT_DISABLE(HS_PORT_DISABLE), .SS_PORT_DISABLE(SS_PORT_DISABLE));
    rsld_strap_board board (.clk(REF_CLK), .released(STRAP_PINS_RELEASED), .setting(setting),
        .straps(straps), .mode_sense(MODE_SENSE), .port_straps(PORT_STRAPS));
    // Resets one source, releases, and checks the capture lands on the sixth edge.
    task automatic capture(input logic [2:0] s, input logic [11:0] st, input logic por);
        @(posedge REF_CLK);
        #2;
        setting = s;
        straps = st;
        if (por) POR_N = 1'b0; else NRST = 1'b0;
        @(posedge REF_CLK);
        #2;
        `CHK(STANDBY, 1'b1)
        `CHK(MODE_CODE, RSLD_MODE_NONE)
        NRST = 1'b1;
        POR_N = 1'b1;
        repeat (5) @(posedge REF_CLK);
        #2;
        `CHK(STRAP_PINS_RELEASED, 1'b0)
        @(posedge REF_CLK);
        #2;
        `CHK(STRAP_PINS_RELEASED, 1'b1)
        `CHK(PORT_STRAPS_CAPTURED, st)
    endtask : capture
    // Every mode setting, plus the invalid strength, from alternating reset sources.
    task automatic t_modes;
        for (int i = 0; i < 8; i++)
        begin
            capture(3'(i), 12'h000, i[0]);
            `CHK(MODE_CODE, (i > 5) ? RSLD_MODE_NONE : 3'(i))
            `CHK(BRIDGE_MASTER, (i == 0))
            `CHK(CONFIG_SLAVE, (i == 1))
            `CHK(MODE_RESERVED, (i > 1))
        end
    endtask : t_modes
    // Single straps alone, both together, and a mixed pattern.
    task automatic t_ports;
        logic [11:0] tbl [4] = '{12'hfc0, 12'h03f, 12'hfff, 12'hade};
        for (int i = 0; i < 4; i++)
        begin
            capture(3'h1, tbl[i], 1'b0);
            `CHK(PORT_STRAPS_CAPTURED, tbl[i])
            `CHK(HS_PORT_DISABLE, tbl[i][11:6] & tbl[i][5:0])
            `CHK(SS_PORT_DISABLE, tbl[i][11:6] & tbl[i][5:0])
        end
    endtask : t_ports
    // Late strap changes are ignored; a reset in mid-settle restarts the sequence.
    task automatic t_hold;
        capture(3'h0, 12'h555, 1'b0);
        setting = 3'h5;
        straps = 12'haaa;
        repeat (20) @(posedge REF_CLK);
        #2;
        `CHK(MODE_CODE, RSLD_BRIDGE_MASTER_SETTING)
        `CHK(PORT_STRAPS_CAPTURED, 12'h555)
        `CHK(STANDBY, 1'b0)
        NRST = 1'b0;
        @(posedge REF_CLK);
        #2;
        `CHK(PORT_STRAPS_CAPTURED, 12'h000)
        NRST = 1'b1;
        repeat (3) @(posedge REF_CLK);
        capture(3'h5, 12'haaa, 1'b1);
        `CHK(MODE_CODE, RSLD_RESERVED_SETTING_D)
    endtask : t_hold
    // Prints the counts and the verdict, then ends the run.
    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test
    // Main sequence; reset falls just after time zero so no process races it, held two edges.
    initial
    begin
        #2;
        NRST = 1'b0;
        POR_N = 1'b0;
        repeat (2) @(posedge REF_CLK);
        #2;
        NRST = 1'b1;
        POR_N = 1'b1;
        t_modes();
        t_ports();
        t_hold();
        end_of_test();
    end
    // Watchdog: the whole run needs well under 300 cycles.
    initial
    begin
        #100000;
        n_mismatch++;
        end_of_test();
    end
endmodule : tb
